//--- cbcs_cpu_end.sv
/*
  Bus interface unit: sequences T1..T4 and Tw, drives min-mode strobes or
  max-mode coded status, keeps the prefetch queue topped up.
  Assumes the memory end answers ready and data as the bus rules say.
*/
`default_nettype none
// How it works
// - ALE pulse in T1, address on bus
// - Upper address held whole cycle
// - Memory/IO select driven T1 through T4
// - Read floats bus, strobe late in T2
// - Far end drives data while read low
// - Min mode drives direction and buffer enable
// - Write data from T2 through T4
// - Write strobe held T2, T3, Tw
// - Write strobe active at start T2
// - Acknowledge like read, bus left floating
// - Two acknowledges, type byte times four
// - Max mode emits three status lines
// - External controller makes strobes in max mode
// - System disables transceiver for local controller
// - Sixteen-bit operand as two byte cycles
// - Prefetch queue holds four bytes
// - Prefetch when one byte free
// - Min mode status zero output
// - Select high means I/O
// - Halt ALE delayed one clock
// - No upper byte enable output
// - Strap high direct strobes, low status
module cbcs_cpu_end
  import cbcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  cbcs_bus_if.cpu bus,
  input wire logic bus_style_strap,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic req_io,
  input wire logic req_word,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic q_pop,
  input wire logic q_flush,
  output logic req_ready,
  output logic done,
  output logic [15:0] rdata,
  output logic [9:0] vector_ptr,
  output logic [7:0] q_head,
  output logic q_empty
);
  cbcs_state_t st_q;
  logic strap_q;
  logic [1:0] kind_q;
  logic io_q;
  logic word_q;
  logic second_q;
  logic prefetch_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] pf_addr_q;
  logic [7:0] ad_out_q;
  logic ad_oe_n_q;
  logic [7:0] upper_q;
  logic ale_q;
  logic rd_n_q;
  logic wr_n_q;
  logic io_sel_q;
  logic interrupt_ack_strobe_n_q;
  logic dtr_q;
  logic den_n_q;
  logic ss0_n_q;
  logic [2:0] cstat_q;
  logic req_ready_q;
  logic done_q;
  logic [15:0] rdata_q;
  logic [9:0] vec_q;
  logic q_push;
  logic [2:0] q_count;
  logic [7:0] q_head_w;
  logic is_min;
  logic rd_like;
  logic [2:0] code;
  logic [7:0] cur_wd;
  logic take_req;
  logic take_pf;
  logic start_t1;
  logic [1:0] n_kind;
  logic n_io;
  logic n_pf;
  logic [15:0] n_addr;

  assign is_min = strap_q;
  assign rd_like = (kind_q == REQ_READ) || (kind_q == REQ_INTERRUPT_ACK_STROBE);
  assign cur_wd = second_q ? wdata_q[15:8] : wdata_q[7:0];
  // Data is only on the bus while the strobe is low, so take it at ready
  assign q_push = (st_q == CBCS_T3 || st_q == CBCS_TW) && bus.ready
    && prefetch_q;
  assign take_req = (st_q == CBCS_TI) && req_valid && !req_ready_q;
  assign take_pf = (st_q == CBCS_TI) && !req_valid && q_count < QCNT_FULL
    && !q_flush;
  assign start_t1 = (take_req && !(req_kind == REQ_HALT && strap_q))
    || take_pf || st_q == CBCS_HW
    || (st_q == CBCS_T4 && !second_q && (word_q || kind_q == REQ_INTERRUPT_ACK_STROBE));

  // Pins for the next T1 come from what is being taken, not from old state
  always_comb begin
    n_kind = kind_q;
    n_io = io_q;
    n_pf = prefetch_q;
    n_addr = addr_q;
    if (take_req) begin
      n_kind = req_kind;
      n_io = req_io;
      n_pf = 1'b0;
      n_addr = req_addr;
    end else if (take_pf) begin
      n_kind = REQ_READ;
      n_io = 1'b0;
      n_pf = 1'b1;
      n_addr = pf_addr_q;
    end else if (st_q == CBCS_T4) begin
      n_addr = addr_q + 16'h0001;
    end
  end

  always_comb begin
    case (n_kind)
      REQ_INTERRUPT_ACK_STROBE: code = ST_INTERRUPT_ACK_STROBE;
      REQ_HALT: code = ST_HALT;
      REQ_WRITE: code = n_io ? ST_IOWR : ST_MWR;
      default: code = n_pf ? ST_CODE : (n_io ? ST_IORD : ST_MRD);
    endcase
  end

  cbcs_queue u_queue (
    .clk(clk),
    .reset_n(reset_n),
    .flush(q_flush),
    .push(q_push),
    .push_data(bus.ad_in),
    .pop(q_pop),
    .head_data(q_head_w),
    .count(q_count)
  );

  // Strap sampled on every clock, under reset as well as after its release
  always_ff @(posedge clk) begin
    strap_q <= bus_style_strap;
  end

  // Sequencer; demand requests beat prefetch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= CBCS_TI;
      kind_q <= REQ_READ;
      io_q <= 1'b0;
      word_q <= 1'b0;
      second_q <= 1'b0;
      prefetch_q <= 1'b0;
      addr_q <= ADDR_ZERO;
      wdata_q <= ADDR_ZERO;
      pf_addr_q <= PF_START;
      req_ready_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= ADDR_ZERO;
      vec_q <= VEC_ZERO;
    end else begin
      req_ready_q <= 1'b0;
      done_q <= 1'b0;
      if (q_flush) begin
        pf_addr_q <= addr_q;
      end
      case (st_q)
        CBCS_TI: begin
          if (req_valid && !req_ready_q) begin
            req_ready_q <= 1'b1;
            kind_q <= req_kind;
            io_q <= req_io;
            word_q <= req_word;
            second_q <= 1'b0;
            prefetch_q <= 1'b0;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            st_q <= (req_kind == REQ_HALT && strap_q) ? CBCS_HW : CBCS_T1;
          end else if (!req_valid && q_count < QCNT_FULL && !q_flush) begin
            kind_q <= REQ_READ;
            io_q <= 1'b0;
            word_q <= 1'b0;
            second_q <= 1'b0;
            prefetch_q <= 1'b1;
            addr_q <= pf_addr_q;
            st_q <= CBCS_T1;
          end
        end
        CBCS_HW: st_q <= CBCS_T1;
        CBCS_T1: st_q <= (kind_q == REQ_HALT) ? CBCS_HH : CBCS_T2;
        CBCS_HH: st_q <= CBCS_HH; // Left only by reset
        CBCS_T2: st_q <= CBCS_T3;
        CBCS_T3, CBCS_TW: begin
          st_q <= bus.ready ? CBCS_T4 : CBCS_TW;
          if (bus.ready && rd_like && !prefetch_q) begin
            if (second_q) begin
              rdata_q[15:8] <= bus.ad_in;
            end else begin
              rdata_q[7:0] <= bus.ad_in;
            end
          end
          if (bus.ready && kind_q == REQ_INTERRUPT_ACK_STROBE && second_q) begin
            vec_q <= {bus.ad_in, 2'b00};
          end
        end
        CBCS_T4: begin
          if (prefetch_q) begin
            pf_addr_q <= pf_addr_q + 16'h0001;
          end
          if (!second_q && (word_q || kind_q == REQ_INTERRUPT_ACK_STROBE)) begin
            second_q <= 1'b1;
            st_q <= CBCS_T1;
          end else begin
            if (!prefetch_q) begin
              done_q <= 1'b1;
            end
            st_q <= CBCS_TI;
          end
        end
        default: st_q <= CBCS_TI;
      endcase
    end
  end

  // Pin timing, registered one edge ahead of each T-state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ad_out_q <= BYTE_ZERO;
      ad_oe_n_q <= 1'b1;
      upper_q <= BYTE_ZERO;
      ale_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      io_sel_q <= IO_SEL_MEM;
      interrupt_ack_strobe_n_q <= 1'b1;
      dtr_q <= 1'b1;
      den_n_q <= 1'b1;
      ss0_n_q <= 1'b1;
      cstat_q <= ST_IDLE;
    end else begin
      ale_q <= 1'b0;
      case (st_q)
        CBCS_T1: begin
          // Entering T2
          ale_q <= 1'b0;
          if (kind_q == REQ_WRITE) begin
            ad_out_q <= cur_wd;
            ad_oe_n_q <= 1'b0;
            wr_n_q <= !is_min;
            den_n_q <= !is_min;
          end else begin
            ad_oe_n_q <= 1'b1;
          end
        end
        CBCS_T2: begin
          // Entering T3: read side strobes one phase later
          if (rd_like) begin
            rd_n_q <= !(is_min && kind_q == REQ_READ);
            interrupt_ack_strobe_n_q <= !(is_min && kind_q == REQ_INTERRUPT_ACK_STROBE);
            den_n_q <= !is_min;
          end
        end
        CBCS_T3, CBCS_TW: begin
          if (bus.ready) begin
            rd_n_q <= 1'b1;
            interrupt_ack_strobe_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            cstat_q <= ST_IDLE;
          end
        end
        CBCS_T4: begin
          den_n_q <= 1'b1;
          ad_oe_n_q <= 1'b1;
        end
        default: ale_q <= 1'b0;
      endcase
      // Entering T1 from idle, from halt delay or between halves
      if (start_t1) begin
        ale_q <= is_min;
        upper_q <= n_addr[15:8];
        io_sel_q <= n_io ? IO_SEL_IO : IO_SEL_MEM;
        if (n_kind != REQ_INTERRUPT_ACK_STROBE) begin
          ad_out_q <= n_addr[7:0];
          ad_oe_n_q <= 1'b0;
        end
        dtr_q <= n_kind == REQ_WRITE;
        ss0_n_q <= !code[0];
        cstat_q <= is_min ? ST_IDLE : code;
      end
    end
  end

  assign bus.ad_out = ad_out_q;
  assign bus.ad_oe_n = ad_oe_n_q;
  assign bus.upper_address_out = upper_q;
  assign bus.ale = ale_q;
  assign bus.rd_n = rd_n_q;
  assign bus.wr_n = wr_n_q;
  assign bus.io_sel = io_sel_q;
  assign bus.interrupt_ack_strobe_n = interrupt_ack_strobe_n_q;
  assign bus.transceiver_direction = dtr_q;
  assign bus.data_buffer_enable_n = den_n_q;
  assign bus.min_mode_status_zero_n = ss0_n_q;
  assign bus.cycle_status = cstat_q;
  assign req_ready = req_ready_q;
  assign done = done_q;
  assign rdata = rdata_q;
  assign vector_ptr = vec_q;
  assign q_head = q_head_w;
  assign q_empty = q_count == 3'h0;
endmodule : cbcs_cpu_end
`default_nettype wire

//--- cbcs_pkg.sv
/*
  Shared constants and types for the bus cycle sequencer and its far end.
  Assumes one clock and an active-low asynchronous reset on both ends.
*/
`default_nettype none
package cbcs_pkg;
  localparam int unsigned QUEUE_DEPTH = 4;
  localparam logic [1:0] QPTR_ONE = 2'h1;
  localparam logic [2:0] QCNT_ONE = 3'h1;
  localparam logic [2:0] QCNT_FULL = 3'h4;
  // Memory/IO select: high means I/O, low means memory
  localparam logic IO_SEL_IO = 1'b1;
  localparam logic IO_SEL_MEM = 1'b0;
  // Coded status {s2,s1,s0}
  localparam logic [2:0] ST_INTERRUPT_ACK_STROBE = 3'h0;
  localparam logic [2:0] ST_IORD = 3'h1;
  localparam logic [2:0] ST_IOWR = 3'h2;
  localparam logic [2:0] ST_HALT = 3'h3;
  localparam logic [2:0] ST_CODE = 3'h4;
  localparam logic [2:0] ST_MRD = 3'h5;
  localparam logic [2:0] ST_MWR = 3'h6;
  localparam logic [2:0] ST_IDLE = 3'h7;
  // Requests from the execution side
  localparam logic [1:0] REQ_READ = 2'h0;
  localparam logic [1:0] REQ_WRITE = 2'h1;
  localparam logic [1:0] REQ_INTERRUPT_ACK_STROBE = 2'h2;
  localparam logic [1:0] REQ_HALT = 2'h3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  localparam logic [9:0] VEC_ZERO = 10'h000;
  localparam logic [15:0] PF_START = 16'h0000;
  typedef enum logic [3:0] {
    CBCS_TI, CBCS_T1, CBCS_T2, CBCS_T3, CBCS_TW, CBCS_T4, CBCS_HW, CBCS_HH
  } cbcs_state_t;
endpackage : cbcs_pkg
`default_nettype wire

//--- cbcs_bus_if.sv
/*
  Local bus between the sequencer and the memory/peripheral end.
  Assumes the bench resolves the shared byte lanes from the enables.
*/
`default_nettype none
interface cbcs_bus_if;
  logic [7:0] ad_out;
  logic ad_oe_n;
  logic [7:0] ad_in;
  logic [7:0] upper_address_out;
  logic ale;
  logic rd_n;
  logic wr_n;
  logic io_sel;
  logic interrupt_ack_strobe_n;
  logic transceiver_direction;
  logic data_buffer_enable_n;
  logic min_mode_status_zero_n;
  logic [2:0] cycle_status;
  logic ready;
  modport cpu (output ad_out, ad_oe_n, upper_address_out, ale, rd_n, wr_n,
    io_sel, interrupt_ack_strobe_n, transceiver_direction,
    data_buffer_enable_n, min_mode_status_zero_n, cycle_status,
    input ad_in, ready);
  modport mem (input ad_out, ad_oe_n, upper_address_out, ale, rd_n, wr_n,
    io_sel, interrupt_ack_strobe_n, cycle_status, output ad_in, ready);
endinterface : cbcs_bus_if
`default_nettype wire

//--- cbcs_queue.sv
/*
  Four-byte instruction prefetch queue in flip-flops.
  Assumes push only when not full and pop only when not empty.
*/
`default_nettype none
module cbcs_queue
  import cbcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] head_data,
  output logic [2:0] count
);
  logic [7:0] mem_q [QUEUE_DEPTH];
  logic [1:0] wr_q;
  logic [1:0] rd_q;
  logic [2:0] cnt_q;

  assign head_data = mem_q[rd_q];
  assign count = cnt_q;

  genvar gi;
  generate
    for (gi = 0; gi < QUEUE_DEPTH; gi++) begin : g_ent
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mem_q[gi] <= BYTE_ZERO;
        end else if (push && wr_q == 2'(gi)) begin
          mem_q[gi] <= push_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + QPTR_ONE;
      end
      if (pop) begin
        rd_q <= rd_q + QPTR_ONE;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + QCNT_ONE;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - QCNT_ONE;
      end
    end
  end
endmodule : cbcs_queue
`default_nettype wire

//--- cbcs_mem_end.sv
/*
  Far end: a small byte memory, an I/O byte and an interrupt type source.
  Assumes the sequencer pin timing of the local bus interface.
*/
`default_nettype none
module cbcs_mem_end
  import cbcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  cbcs_bus_if.mem bus,
  input wire logic [7:0] irq_type,
  input wire logic [1:0] wait_cycles,
  output logic [7:0] io_reg,
  output logic [7:0] last_wr_addr
);
  logic [7:0] mem_q [16];
  logic [7:0] lat_q;
  logic [7:0] dout_q;
  logic [1:0] wcnt_q;
  logic ready_q;
  logic [7:0] io_q;
  logic interrupt_ack_strobe_seen_q;
  logic strobe_n;
  logic [2:0] stat_q;
  logic [1:0] ph_q;
  logic ale_any;
  logic rd_act;
  logic wr_act;
  logic ack_act;

  // Status decode stands in for the external bus controller
  assign ale_any = bus.ale
    || (stat_q == ST_IDLE && bus.cycle_status != ST_IDLE);
  assign rd_act = !bus.rd_n || (ph_q == 2'h2 && (bus.cycle_status == ST_CODE
    || bus.cycle_status == ST_MRD || bus.cycle_status == ST_IORD));
  assign ack_act = !bus.interrupt_ack_strobe_n
    || (ph_q == 2'h2 && bus.cycle_status == ST_INTERRUPT_ACK_STROBE);
  assign wr_act = !bus.wr_n || (ph_q != 2'h0
    && (bus.cycle_status == ST_MWR || bus.cycle_status == ST_IOWR));
  assign strobe_n = !(rd_act || ack_act);

  // Coded-status phase: 1 in T2, 2 from T3 until status goes idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= ST_IDLE;
      ph_q <= 2'h0;
    end else begin
      stat_q <= bus.cycle_status;
      if (bus.cycle_status == ST_IDLE) begin
        ph_q <= 2'h0;
      end else if (ph_q != 2'h2) begin
        ph_q <= ph_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lat_q <= BYTE_ZERO;
    end else if (ale_any) begin
      lat_q <= bus.ad_out;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_mem
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mem_q[gi] <= 8'(gi);
        end else if (wr_act && bus.io_sel == IO_SEL_MEM
                     && lat_q[3:0] == 4'(gi) && ready_q) begin
          mem_q[gi] <= bus.ad_out;
        end
      end
    end
  endgenerate

  // Data driven while read strobe low, ready after wait count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wcnt_q <= '0;
      ready_q <= 1'b0;
      dout_q <= BYTE_ZERO;
      io_q <= BYTE_ZERO;
      interrupt_ack_strobe_seen_q <= 1'b0;
    end else begin
      if (!strobe_n || wr_act) begin
        if (wcnt_q == wait_cycles) begin
          ready_q <= 1'b1;
        end else begin
          wcnt_q <= wcnt_q + 2'h1;
        end
        if (ack_act) begin
          dout_q <= interrupt_ack_strobe_seen_q ? irq_type : BYTE_ZERO;
        end else if (bus.io_sel == IO_SEL_IO) begin
          dout_q <= io_q;
        end else begin
          dout_q <= mem_q[lat_q[3:0]];
        end
        if (wr_act && bus.io_sel == IO_SEL_IO && ready_q) begin
          io_q <= bus.ad_out;
        end
      end else begin
        wcnt_q <= '0;
        ready_q <= 1'b0;
      end
      if (ack_act && ready_q) begin
        interrupt_ack_strobe_seen_q <= !interrupt_ack_strobe_seen_q;
      end
    end
  end

  assign bus.ad_in = strobe_n ? BYTE_ZERO : dout_q;
  assign bus.ready = ready_q;
  assign io_reg = io_q;
  assign last_wr_addr = lat_q;
endmodule : cbcs_mem_end
`default_nettype wire

//--- cbcs_monitor.sv
/*
  Checker for the local bus between the sequencer and the far end.
  Assumes one clock domain; inputs come straight from the interface.
*/
`default_nettype none
module cbcs_monitor
  import cbcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bus_style_strap,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic interrupt_ack_strobe_n,
  input wire logic io_sel,
  input wire logic ad_oe_n,
  input wire logic ready,
  input wire logic transceiver_direction,
  input wire logic [7:0] upper_address_out,
  input wire logic [2:0] cycle_status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_ale_one_pulse: assert property ($rose(ale) |=> !ale)
    else $error("ale high for more than one cycle");
  chk_upper_addr_hold: assert property (
    (!rd_n || !wr_n || !interrupt_ack_strobe_n)
    |-> $stable(upper_address_out)) else $error("upper address moved");
  chk_space_sel_hold: assert property (
    (!rd_n || !wr_n || !interrupt_ack_strobe_n) |-> $stable(io_sel))
    else $error("io select moved inside a cycle");
  chk_read_bus_free: assert property (
    (!rd_n || !interrupt_ack_strobe_n) |-> ad_oe_n)
    else $error("bus driven during read strobe");
  chk_read_late: assert property (
    $fell(rd_n) |-> !$past(ale) && $past(ale, 2))
    else $error("read strobe not one clock into T2");
  chk_read_answer: assert property ($fell(rd_n) |-> ##[1:8] rd_n)
    else $error("read never answered");
  chk_write_data_on: assert property (!wr_n |-> !ad_oe_n)
    else $error("write data not driven");
  chk_write_held: assert property ($fell(wr_n) |-> !wr_n[*2])
    else $error("write strobe dropped before T3 ended");
  chk_write_at_t2: assert property ($fell(wr_n) |-> $past(ale))
    else $error("write strobe not at start of T2");
  chk_wait_holds: assert property ((!rd_n && !ready) |=> !rd_n)
    else $error("read strobe released while not ready");
  chk_min_direction: assert property (
    (bus_style_strap && !wr_n) |-> transceiver_direction)
    else $error("direction not transmit on write");
  chk_min_no_status: assert property (
    (bus_style_strap && $past(bus_style_strap))
    |-> cycle_status == ST_IDLE) else $error("status coded in min mode");
endmodule : cbcs_monitor
`default_nettype wire

//--- tb_cpu_bus_cycle_sequencer.sv
/*
  Self-checking bench: sequencer and far end joined by the local bus.
  Assumes package and interface are compiled first.
*/
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  err_count++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module tb_cpu_bus_cycle_sequencer
  import cbcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic bus_style_strap = 1'b1;
  logic req_valid = 1'b0;
  logic req_io = 1'b0;
  logic req_word = 1'b0;
  logic q_pop = 1'b0;
  logic q_flush = 1'b0;
  logic [1:0] req_kind = REQ_READ;
  logic [1:0] wait_cycles = 2'h0;
  logic [15:0] req_addr = ADDR_ZERO;
  logic [15:0] req_wdata = 16'h0000;
  logic [7:0] irq_type = BYTE_ZERO;
  logic req_ready, done, q_empty, io_q;
  logic [15:0] rdata;
  logic [9:0] vector_ptr;
  logic [7:0] q_head, io_reg, last_wr_addr, up_q;
  logic [2:0] first_st;
  int err_count = 0;
  int total_checks = 0;
  int ale_cnt, ack_cnt, cyc, ale_at, req_cyc;
  cbcs_bus_if bus();
  cbcs_cpu_end i_cbcs_cpu_end (.clk, .reset_n, .bus(bus.cpu),
    .bus_style_strap, .req_valid, .req_kind, .req_io, .req_word, .req_addr,
    .req_wdata, .q_pop, .q_flush, .req_ready, .done, .rdata, .vector_ptr,
    .q_head, .q_empty);
  cbcs_mem_end i_cbcs_mem_end (.clk, .reset_n, .bus(bus.mem), .irq_type,
    .wait_cycles, .io_reg, .last_wr_addr);
  cbcs_monitor i_cbcs_monitor (.clk, .reset_n, .bus_style_strap,
    .ale(bus.ale), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .interrupt_ack_strobe_n(bus.interrupt_ack_strobe_n),
    .io_sel(bus.io_sel), .ad_oe_n(bus.ad_oe_n), .ready(bus.ready),
    .transceiver_direction(bus.transceiver_direction),
    .upper_address_out(bus.upper_address_out),
    .cycle_status(bus.cycle_status));
  always #25 clk = ~clk;
  // Sampled mid-cycle so edge updates have landed
  always @(negedge clk) begin
    cyc++;
    if (bus.ale && ale_cnt == 0) ale_at = cyc;
    if (bus.ale) begin
      ale_cnt++;
      up_q = bus.upper_address_out;
      io_q = bus.io_sel;
    end
    if ($fell(bus.interrupt_ack_strobe_n)) ack_cnt++;
    if (first_st === ST_IDLE && bus.cycle_status !== ST_IDLE)
      first_st = bus.cycle_status;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic wait_hi(input bit on_done);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((on_done ? done : req_ready) !== 1'b1 && n < 300);
    `CHK(n < 300, 1'b1)
  endtask : wait_hi
  task automatic do_req(input logic [1:0] k, input logic io, input logic w,
    input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    ale_cnt = 0;
    ack_cnt = 0;
    first_st = ST_IDLE;
    req_cyc = cyc;
    req_kind <= k;
    req_io <= io;
    req_word <= w;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    wait_hi(1'b0);
    @(posedge clk);
    req_valid <= 1'b0;
    if (k == REQ_HALT) repeat (10) @(posedge clk);
    else wait_hi(1'b1);
  endtask : do_req
  task automatic pulse(input bit pop);
    @(posedge clk);
    if (pop) q_pop <= 1'b1;
    else q_flush <= 1'b1;
    @(posedge clk);
    q_pop <= 1'b0;
    q_flush <= 1'b0;
  endtask : pulse
  initial begin
    #(20000 * 50);
    err_count++;
    finish_test();
  end
  initial begin
    logic [15:0] a, w1, w2;
    logic [31:0] e;
    logic [7:0] t;
    logic [2:0] st_exp [5];
    int rd_lat;
    st_exp = '{ST_MRD, ST_IORD, ST_MWR, ST_IOWR, ST_INTERRUPT_ACK_STROBE};
    void'($urandom(32'h65cd));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    ale_cnt = 0;
    repeat (100) @(posedge clk);
    `CHK(ale_cnt, 4)
    pulse(1'b1);
    ale_cnt = 0;
    repeat (30) @(posedge clk);
    `CHK(ale_cnt, 1)
    for (int i = 0; i < 6; i++) begin
      a = {8'($urandom), 4'h0, 3'($urandom_range(0, 5)), 1'b0};
      w1 = 16'($urandom);
      w2 = 16'($urandom);
      t = 8'($urandom);
      wait_cycles <= 2'($urandom);
      // Word write lands as two byte cycles
      do_req(REQ_WRITE, 1'b0, 1'b1, a, w1);
      `CHK(ale_cnt, 2)
      `CHK(up_q, a[15:8])
      `CHK(io_q, IO_SEL_MEM)
      `CHK(last_wr_addr, a[7:0] + 8'h1)
      do_req(REQ_WRITE, 1'b0, 1'b1, a + 16'h2, w2);
      do_req(REQ_READ, 1'b0, 1'b1, a, 16'h0000);
      `CHK(rdata, w1)
      pulse(1'b0);
      repeat (60) @(posedge clk);
      e = {w2, w1};
      for (int j = 0; j < 4; j++) begin
        @(negedge clk);
        `CHK(q_head, e[8 * j +: 8])
        pulse(1'b1);
      end
      repeat (60) @(posedge clk);
      do_req(REQ_WRITE, 1'b1, 1'b0, {8'h00, t}, {8'h00, t});
      `CHK(io_reg, t)
      `CHK(io_q, IO_SEL_IO)
      do_req(REQ_READ, 1'b1, 1'b0, {8'h00, t}, 16'h0000);
      `CHK(rdata[7:0], t)
      rd_lat = ale_at - req_cyc;
      irq_type <= t;
      do_req(REQ_INTERRUPT_ACK_STROBE, 1'b0, 1'b0, a, 16'h0000);
      `CHK(vector_ptr, {t, 2'h0})
      `CHK(ack_cnt, 2)
      `CHK(ale_cnt, 2)
    end
    // Coded status for every requested cycle kind; code fetch status is not checked
    bus_style_strap <= 1'b0;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      do_req(k < 4 ? 2'(k / 2) : REQ_INTERRUPT_ACK_STROBE, k % 2 == 1, 1'b0, a, 16'h0055);
      `CHK(first_st, st_exp[k])
    end
    do_req(REQ_HALT, 1'b0, 1'b0, a, 16'h0000);
    `CHK(first_st, ST_HALT)
    // Halt is left only by reset
    @(posedge clk);
    reset_n <= 1'b0;
    bus_style_strap <= 1'b1;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (100) @(posedge clk);
    do_req(REQ_HALT, 1'b0, 1'b0, a, 16'h0000);
    `CHK(ale_at - req_cyc, rd_lat + 1)
    finish_test();
  end
endmodule : tb_cpu_bus_cycle_sequencer
`default_nettype wire
